/* sim/adc_link_props.sv */
`timescale 1ns/10ps
module adc_link_props (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic cs_n,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic [7:0] data_line,
    input wire logic done_n,
    input wire logic done_oe,
    input wire logic d_dev_oe,
    input wire logic TRACK,
    input wire logic CAP_ON_NEG,
    input wire logic EXT_CLK_MODE
);
    localparam int TE = 2 * adc_seq_pkg::EXT_CCLK_HALF;
    localparam int TI = 2 * adc_seq_pkg::INT_CCLK_HALF;
    localparam int N = adc_seq_pkg::CONV_CYCLES;
    logic ext_acq_q;
    logic int_acq_q;
    int acq_q;
    int conv_q;
    int t;
    assign t = EXT_CLK_MODE ? TE : TI;
    // counts run from the last accepted write, so an abort restarts them
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            ext_acq_q <= 1'b0;
            int_acq_q <= 1'b0;
            acq_q <= 0;
            conv_q <= 0;
        end else if ($rose(wr_n) && !cs_n) begin
            ext_acq_q <= data_line[5] && data_line[7];
            int_acq_q <= !data_line[5] && data_line[7] && !ext_acq_q;
            acq_q <= 0;
            conv_q <= 0;
        end else begin
            if (TRACK) begin
                acq_q <= acq_q + 1;
            end
            if (CAP_ON_NEG) begin
                conv_q <= conv_q + 1;
            end
        end
    end
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);
    sequence wr_take;
        $rose(wr_n) && !cs_n;
    endsequence
    track_start_a: assert property (wr_take ##0 (data_line[7] && data_line[5])
        |-> ##[1:4] TRACK) else $error("tracking did not start after write");
    hold_second_a: assert property (wr_take ##0 (!data_line[5] && ext_acq_q)
        |-> ##[1:4] (CAP_ON_NEG && !TRACK)) else $error("second write did not hold");
    acq_len_a: assert property ($rose(CAP_ON_NEG) && int_acq_q
        |-> acq_q >= 2 * t && acq_q <= 4 * t + 4) else $error("acquisition length wrong");
    // internally timed starts sit on a clock fall, so the count is whole
    conv_len_a: assert property ($fell(done_n) && int_acq_q
        |-> conv_q >= N * t - 4 && conv_q <= N * t + 4) else $error("conversion length wrong");
    // a host-timed start lands anywhere in a period: first cycle is partial
    conv_len_host_a: assert property ($fell(done_n) && !int_acq_q
        |-> conv_q >= N * t - t && conv_q <= N * t + 1) else $error("host conversion wrong");
    done_clr_rd_a: assert property (!done_n && $fell(rd_n) && !cs_n
        |-> ##[1:3] done_n) else $error("read did not clear done");
    done_clr_wr_a: assert property (!done_n ##0 wr_take
        |-> ##[1:3] done_n) else $error("write did not clear done");
    done_stands_a: assert property (!done_n && rd_n && wr_n && $stable(wr_n)
        |=> !done_n) else $error("done flag dropped early");
    deselect_float_a: assert property (cs_n [*3]
        |-> !done_oe && !d_dev_oe) else $error("outputs driven while deselected");
    conv_abort_a: assert property (CAP_ON_NEG ##0 wr_take ##0 data_line[7]
        |-> ##[1:4] (TRACK && !CAP_ON_NEG)) else $error("conversion not aborted");
    conv_seen_c: cover property ($fell(done_n));
endmodule

/* sim/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
    typedef struct packed {
        logic [7:0] ctl;
        logic comp;
        logic [9:0] res;
    } row_t;
    // comparator tied per row: all-ones or all-zeros codes need no analog model
    row_t rows [4] = '{'{8'hF1, 1'b1, 10'h3FF}, '{8'hCE, 1'b0, 10'h000},
        '{8'hB5, 1'b1, 10'h3FF}, '{8'h8B, 1'b0, 10'h000}};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic comp_gt = 1'b0;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic track, cap_on_neg, neg_on_ret, unipolar, ext_mode, busy;
    logic [2:0] pos_ch, neg_ch;
    logic [1:0] power_mode;
    logic [9:0] dac_code, result;
    logic [31:0] v;
    int num_errors = 0;
    int check_count = 0;
    adc_bus_if bus ();
    adc_host_end i_adc_host_end (.CLK(clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
        .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP(hresp),
        .BUS(bus.host));
    adc_device_end i_adc_device_end (.CLK(clk), .RSTN(rstn), .BUS(bus.dev),
        .COMP_GT(comp_gt), .TRACK(track), .CAP_ON_NEG(cap_on_neg), .POS_CH(pos_ch),
        .NEG_CH(neg_ch), .NEG_ON_RETURN(neg_on_ret), .UNIPOLAR(unipolar),
        .POWER_MODE(power_mode), .EXT_CLK_MODE(ext_mode), .BUSY(busy),
        .DAC_CODE(dac_code), .RESULT(result));
    adc_link_props i_adc_link_props (.CLK(clk), .RSTN(rstn), .cs_n(bus.cs_n),
        .wr_n(bus.wr_n), .rd_n(bus.rd_n), .data_line(bus.data_line), .done_n(bus.done_n),
        .done_oe(bus.done_oe), .d_dev_oe(bus.d_dev_oe), .TRACK(track),
        .CAP_ON_NEG(cap_on_neg), .EXT_CLK_MODE(ext_mode));
    initial begin
        forever #10 clk = ~clk;
    end
    task check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task print_verdict();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // entered just after a rising edge; hready is waited on, never assumed
    task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
        input logic [2:0] sz, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= a;
        hsize <= sz;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask
    task do_reset();
        rstn <= 1'b0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        check_word("ext mode", 32'h1, {31'h0, ext_mode});
        check_word("busy", 32'h0, {31'h0, busy});
        check_word("result", 32'h0, {22'h0, result});
        check_word("done line", 32'h1, {31'h0, bus.done_line});
    endtask
    task run_row(input row_t r);
        int n;
        comp_gt <= r.comp;
        ahb(1'b1, {24'h0, adc_seq_pkg::CMD_OFS}, 32'h0000_0100 | r.ctl, 3'h2, v);
        n = 0;
        v = 32'h0000_0000;
        while (v !== 32'h0000_0002 && n < 2000) begin
            ahb(1'b0, {24'h0, adc_seq_pkg::STAT_OFS}, 32'h0, 3'h2, v);
            n++;
        end
        check_word("status", 32'h0000_0002, v);
        ahb(1'b0, {24'h0, adc_seq_pkg::RES_OFS}, 32'h0, 3'h2, v);
        check_word("result reg", {22'h0, r.res}, v);
        check_word("result pin", {22'h0, r.res}, {22'h0, result});
        check_word("pos ch", {29'h0, r.ctl[2:0]}, {29'h0, pos_ch});
        check_word("neg ch", {29'h0, r.ctl[2:0] ^ 3'h1}, {29'h0, neg_ch});
        check_word("neg return", {31'h0, r.ctl[4]}, {31'h0, neg_on_ret});
        check_word("unipolar", {31'h0, r.ctl[3]}, {31'h0, unipolar});
        check_word("power", {30'h0, r.ctl[7:6]}, {30'h0, power_mode});
        check_word("clock mode", {31'h0, r.ctl[6]}, {31'h0, ext_mode});
        check_word("dac code", {22'h0, r.res}, {22'h0, dac_code});
        check_word("resp", 32'h0, {31'h0, hresp});
        ahb(1'b0, {24'h0, adc_seq_pkg::CMD_OFS}, 32'h0, 3'h2, v);
        check_word("cmd reg", {24'h0, r.ctl}, v);
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        print_verdict();
    end
    initial begin
        do_reset();
        ahb(1'b0, {24'h0, adc_seq_pkg::STAT_OFS}, 32'h0, 3'h2, v);
        check_word("status rst", 32'h0, v);
        ahb(1'b1, {24'h0, adc_seq_pkg::ACQ_OFS}, 32'h0000_0005, 3'h1, v);
        ahb(1'b0, {24'h0, adc_seq_pkg::ACQ_OFS}, 32'h0, 3'h2, v);
        check_word("acq len", {16'h0, adc_seq_pkg::ACQ_LEN_RST}, v);
        ahb(1'b0, 32'h0000_0010, 32'h0, 3'h2, v);
        check_word("unmapped", 32'h0, v);
        for (int i = 0; i < 4; i++) begin
            run_row(rows[i]);
        end
        // standby after an internal-clock row: clock mode must stay internal
        ahb(1'b1, {24'h0, adc_seq_pkg::CMD_OFS}, 32'h0000_0159, 3'h2, v);
        for (int n = 0; n < 100 && power_mode !== adc_seq_pkg::PCS_STANDBY; n++) @(posedge clk);
        repeat (40) @(posedge clk);
        check_word("off power", {30'h0, adc_seq_pkg::PCS_STANDBY}, {30'h0, power_mode});
        check_word("off clock", 32'h0, {31'h0, ext_mode});
        check_word("off busy", 32'h0, {31'h0, busy});
        do_reset();
        print_verdict();
    end
endmodule

/* src/adc_bus_if.sv */
`timescale 1ns/10ps
interface adc_bus_if;
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic hi_byte;
    logic [7:0] d_host;
    logic d_host_oe;
    logic [7:0] d_dev;
    logic d_dev_oe;
    logic done_n;
    logic done_oe;
    logic ext_cclk;
    logic [7:0] data_line;
    logic done_line;
    // undriven lines float high, as with a weak pull-up
    assign data_line = d_dev_oe ? d_dev : (d_host_oe ? d_host : 8'hFF);
    assign done_line = done_oe ? done_n : 1'b1;
    modport dev (
        input cs_n, wr_n, rd_n, hi_byte, data_line, ext_cclk,
        output d_dev, d_dev_oe, done_n, done_oe
    );
    modport host (
        output cs_n, wr_n, rd_n, hi_byte, d_host, d_host_oe, ext_cclk,
        input data_line, done_line
    );
endinterface

/* src/adc_device_end.sv */
// Notes on behaviour
// - tracking starts on write strobe rising edge
// - host-timed mode holds on next write rise
// - internal mode holds on fourth conversion-clock fall
// - conversion ends on the 13th conversion-clock fall after its start
// - write during conversion aborts, restarts acquisition
// - timing select 0 starts internally timed acquisition
// - three-cycle acquisition, then conversion starts itself
// - host-timed mode needs two write pulses
// - second write, timing 0, starts conversion
// - host keeps channel bits across both writes
// - done flag falls when result valid
// - done flag rises on read or write
// - host starts conversion by writing control byte
// - mux routes channel and return per pairing
// - hold cap moves, DAC resolves 10 bits
// - byte taken on strobe rise, select low
// - select high floats done flag and data
// - control byte field layout fixed
// - power and clock select code meanings
//
// Implementation choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/10ps
module adc_device_end #(
    parameter int RES_W = adc_seq_pkg::RES_W
) (
    input wire logic CLK,
    input wire logic RSTN,
    adc_bus_if.dev BUS,
    input wire logic COMP_GT,
    output logic TRACK,
    output logic CAP_ON_NEG,
    output logic [2:0] POS_CH,
    output logic [2:0] NEG_CH,
    output logic NEG_ON_RETURN,
    output logic UNIPOLAR,
    output logic [1:0] POWER_MODE,
    output logic EXT_CLK_MODE,
    output logic BUSY,
    output logic [RES_W-1:0] DAC_CODE,
    output logic [RES_W-1:0] RESULT
);
    typedef struct packed {
        adc_seq_pkg::dev_state_t st;
        logic [7:0] ctrl;
        logic [2:0] neg_ch;
        logic ext_mode;
        logic [3:0] edges;
        logic wr_prev;
        logic rd_prev;
        logic cclk_prev;
        logic int_cclk;
        logic [3:0] div;
        logic done_n;
        logic done_oe;
        logic dout_oe;
        logic [7:0] dout;
        logic track;
        logic cap_on_neg;
        logic sar_start;
        logic sar_step;
        logic busy;
        logic [RES_W-1:0] dac;
        logic [RES_W-1:0] result;
    } dev_regs_t;

    dev_regs_t r_q;
    dev_regs_t r_d;
    logic cclk;
    logic cfall;
    logic wr_rise;
    logic rd_fall;
    logic rd_rise;
    logic [1:0] pcs;
    logic [RES_W-1:0] sar_code;

    function automatic dev_regs_t start_conv(input dev_regs_t s);
        dev_regs_t t;
        t = s;
        t.st = adc_seq_pkg::D_CONV;
        t.edges = 4'h0;
        t.track = 1'b0;
        t.cap_on_neg = 1'b1;
        t.sar_start = 1'b1;
        t.busy = 1'b1;
        return t;
    endfunction

    sar_core #(
        .W(RES_W)
    ) u_sar (
        .clk(CLK),
        .rstn(RSTN),
        .start(r_q.sar_start),
        .step(r_q.sar_step),
        .comp_gt(COMP_GT),
        .code(sar_code)
    );

    // a change of clock source can fake one edge; only writes change it
    assign cclk = r_q.ext_mode ? BUS.ext_cclk : r_q.int_cclk;
    assign cfall = r_q.cclk_prev & ~cclk;
    assign wr_rise = BUS.wr_n & ~r_q.wr_prev;
    assign rd_fall = ~BUS.rd_n & r_q.rd_prev;
    assign rd_rise = BUS.rd_n & ~r_q.rd_prev;
    assign pcs = BUS.data_line[adc_seq_pkg::PCS_HI:adc_seq_pkg::PCS_LO];

    always_comb begin
        r_d = r_q;
        r_d.sar_start = 1'b0;
        r_d.sar_step = 1'b0;
        r_d.wr_prev = BUS.wr_n;
        r_d.rd_prev = BUS.rd_n;
        r_d.cclk_prev = cclk;
        r_d.dac = sar_code;
        if (r_q.div == 4'(adc_seq_pkg::INT_CCLK_HALF - 1)) begin
            r_d.div = 4'h0;
            r_d.int_cclk = ~r_q.int_cclk;
        end else begin
            r_d.div = r_q.div + 4'h1;
        end
        r_d.done_oe = ~BUS.cs_n;
        if (BUS.cs_n || rd_rise) begin
            r_d.dout_oe = 1'b0;
        end
        if (rd_fall && !BUS.cs_n) begin
            r_d.done_n = 1'b1;
            r_d.dout_oe = 1'b1;
            if (BUS.hi_byte) begin
                r_d.dout = 8'(r_q.result >> 8);
            end else begin
                r_d.dout = r_q.result[7:0];
            end
        end
        case (r_q.st)
            adc_seq_pkg::D_ACQ_INT: begin
                if (cfall) begin
                    r_d.edges = r_q.edges + 4'h1;
                    if (r_q.edges == 4'(adc_seq_pkg::ACQ_HOLD_EDGE - 1)) begin
                        r_d = start_conv(r_d);
                    end
                end
            end
            adc_seq_pkg::D_CONV: begin
                if (cfall) begin
                    r_d.edges = r_q.edges + 4'h1;
                    if (r_q.edges < 4'(RES_W)) begin
                        r_d.sar_step = 1'b1;
                    end
                    if (r_q.edges == 4'(adc_seq_pkg::CONV_CYCLES - 1)) begin
                        r_d.result = sar_code;
                        r_d.done_n = 1'b0;
                        r_d.cap_on_neg = 1'b0;
                        r_d.busy = 1'b0;
                        if (r_q.ctrl[adc_seq_pkg::PCS_HI]) begin
                            r_d.st = adc_seq_pkg::D_IDLE;
                        end else begin
                            r_d.st = adc_seq_pkg::D_OFF;
                        end
                    end
                end
            end
            default: begin
            end
        endcase
        if (wr_rise && !BUS.cs_n) begin
            r_d.ctrl = BUS.data_line;
            r_d.done_n = 1'b1;
            // pair partner whatever the pairing; NEG_ON_RETURN flags the return pin
            r_d.neg_ch = BUS.data_line[adc_seq_pkg::CH_HI:0] ^ 3'h1;
            if (pcs[1]) begin
                r_d.ext_mode = (pcs == adc_seq_pkg::PCS_EXT_CLK);
            end
            if ((r_q.st == adc_seq_pkg::D_ACQ_EXT) &&
                !BUS.data_line[adc_seq_pkg::TIMING_BIT]) begin
                r_d = start_conv(r_d);
            end else if (!pcs[1]) begin
                // power-down codes keep the previous clock source
                r_d.st = adc_seq_pkg::D_OFF;
                r_d.track = 1'b0;
                r_d.cap_on_neg = 1'b0;
                r_d.busy = 1'b0;
            end else begin
                // also the abort path of a running conversion
                r_d.edges = 4'h0;
                r_d.track = 1'b1;
                r_d.cap_on_neg = 1'b0;
                r_d.busy = 1'b1;
                if (BUS.data_line[adc_seq_pkg::TIMING_BIT]) begin
                    r_d.st = adc_seq_pkg::D_ACQ_EXT;
                end else begin
                    r_d.st = adc_seq_pkg::D_ACQ_INT;
                end
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            r_q <= '0;
            r_q.ctrl <= adc_seq_pkg::CTRL_RST;
            r_q.neg_ch <= 3'h1;
            r_q.ext_mode <= adc_seq_pkg::EXT_MODE_RST;
            r_q.done_n <= 1'b1;
            r_q.wr_prev <= 1'b1;
            r_q.rd_prev <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    assign BUS.d_dev = r_q.dout;
    assign BUS.d_dev_oe = r_q.dout_oe;
    assign BUS.done_n = r_q.done_n;
    assign BUS.done_oe = r_q.done_oe;
    assign TRACK = r_q.track;
    assign CAP_ON_NEG = r_q.cap_on_neg;
    assign POS_CH = r_q.ctrl[adc_seq_pkg::CH_HI:0];
    assign NEG_CH = r_q.neg_ch;
    assign NEG_ON_RETURN = r_q.ctrl[adc_seq_pkg::PAIRING_BIT];
    assign UNIPOLAR = r_q.ctrl[adc_seq_pkg::POLARITY_BIT];
    assign POWER_MODE = r_q.ctrl[adc_seq_pkg::PCS_HI:adc_seq_pkg::PCS_LO];
    assign EXT_CLK_MODE = r_q.ext_mode;
    assign BUSY = r_q.busy;
    assign DAC_CODE = r_q.dac;
    assign RESULT = r_q.result;
endmodule

/* src/adc_host_end.sv */
`timescale 1ns/10ps
module adc_host_end #(
    parameter int RES_W = adc_seq_pkg::RES_W
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic [31:0] HRDATA,
    output logic HRESP,
    adc_bus_if.host BUS
);
    typedef struct packed {
        adc_seq_pkg::host_state_t st;
        logic [15:0] cnt;
        logic [7:0] ctrl;
        logic second;
        logic [15:0] acq_len;
        logic [RES_W-1:0] res;
        logic busy;
        logic done_seen;
        logic cs_n;
        logic wr_n;
        logic rd_n;
        logic hi;
        logic [7:0] dout;
        logic d_oe;
        logic [4:0] div;
        logic ecclk;
        logic a_valid;
        logic a_write;
        logic [7:0] a_addr;
        logic [31:0] hrdata;
        logic hready;
    } host_regs_t;

    host_regs_t r_q;
    host_regs_t r_d;
    logic addr_ok;

    function automatic host_regs_t finish(input host_regs_t s);
        host_regs_t t;
        t = s;
        t.st = adc_seq_pkg::H_IDLE;
        t.cs_n = 1'b1;
        t.busy = 1'b0;
        return t;
    endfunction

    function automatic logic [31:0] rd_mux(input host_regs_t s, input logic [7:0] a);
        case (a)
            adc_seq_pkg::CMD_OFS: rd_mux = 32'(s.ctrl);
            adc_seq_pkg::ACQ_OFS: rd_mux = 32'(s.acq_len);
            adc_seq_pkg::STAT_OFS: rd_mux = 32'({s.done_seen, s.busy});
            adc_seq_pkg::RES_OFS: rd_mux = 32'(s.res);
            default: rd_mux = 32'h0000_0000;
        endcase
    endfunction

    // only whole-word transfers are honoured, NONSEQ or SEQ
    assign addr_ok = HSEL & HREADY & HTRANS[1] & (HSIZE == 3'h2);

    always_comb begin
        r_d = r_q;
        r_d.hready = 1'b1;
        if (r_q.div == 5'(adc_seq_pkg::EXT_CCLK_HALF - 1)) begin
            r_d.div = 5'h00;
            r_d.ecclk = ~r_q.ecclk;
        end else begin
            r_d.div = r_q.div + 5'h01;
        end
        r_d.a_valid = addr_ok;
        r_d.a_write = HWRITE;
        r_d.a_addr = HADDR[7:0];
        if (addr_ok && !HWRITE) begin
            r_d.hrdata = rd_mux(r_q, HADDR[7:0]);
        end
        if (r_q.a_valid && r_q.a_write) begin
            if (r_q.a_addr == adc_seq_pkg::ACQ_OFS) begin
                r_d.acq_len = HWDATA[15:0];
            end
            // a command while busy is dropped
            if ((r_q.a_addr == adc_seq_pkg::CMD_OFS) && HWDATA[adc_seq_pkg::GO_BIT] &&
                !r_q.busy) begin
                r_d.ctrl = HWDATA[7:0];
                r_d.busy = 1'b1;
                r_d.done_seen = 1'b0;
                r_d.second = 1'b0;
                r_d.cs_n = 1'b0;
                r_d.dout = HWDATA[7:0];
                r_d.d_oe = 1'b1;
                r_d.wr_n = 1'b0;
                r_d.cnt = 16'h0000;
                r_d.st = adc_seq_pkg::H_WR_LO;
            end
        end
        case (r_q.st)
            adc_seq_pkg::H_WR_LO: begin
                r_d.cnt = r_q.cnt + 16'h0001;
                if (r_q.cnt == 16'(adc_seq_pkg::WR_LOW_CYC - 1)) begin
                    r_d.wr_n = 1'b1;
                    r_d.st = adc_seq_pkg::H_WR_HI;
                end
            end
            adc_seq_pkg::H_WR_HI: begin
                // data held through the rising edge cycle
                r_d.d_oe = 1'b0;
                r_d.cnt = 16'h0000;
                if (!r_q.ctrl[adc_seq_pkg::PCS_HI]) begin
                    r_d = finish(r_d);
                end else if (r_q.ctrl[adc_seq_pkg::TIMING_BIT] && !r_q.second) begin
                    r_d.st = adc_seq_pkg::H_ACQ;
                end else begin
                    r_d.st = adc_seq_pkg::H_WAIT;
                end
            end
            adc_seq_pkg::H_ACQ: begin
                r_d.cnt = r_q.cnt + 16'h0001;
                if (r_q.cnt >= r_q.acq_len) begin
                    // same byte, only the timing bit cleared
                    r_d.dout = r_q.ctrl;
                    r_d.dout[adc_seq_pkg::TIMING_BIT] = 1'b0;
                    r_d.second = 1'b1;
                    r_d.d_oe = 1'b1;
                    r_d.wr_n = 1'b0;
                    r_d.cnt = 16'h0000;
                    r_d.st = adc_seq_pkg::H_WR_LO;
                end
            end
            adc_seq_pkg::H_WAIT: begin
                // select stays low, else the done flag floats
                if (!BUS.done_line) begin
                    r_d.rd_n = 1'b0;
                    r_d.hi = 1'b0;
                    r_d.cnt = 16'h0000;
                    r_d.st = adc_seq_pkg::H_RD_LO;
                end
            end
            adc_seq_pkg::H_RD_LO: begin
                r_d.cnt = r_q.cnt + 16'h0001;
                if (r_q.cnt == 16'(adc_seq_pkg::RD_LOW_CYC - 1)) begin
                    r_d.rd_n = 1'b1;
                    r_d.st = adc_seq_pkg::H_RD_GAP;
                    if (r_q.hi) begin
                        r_d.res[RES_W-1:8] = BUS.data_line[RES_W-9:0];
                    end else begin
                        r_d.res[7:0] = BUS.data_line;
                    end
                end
            end
            adc_seq_pkg::H_RD_GAP: begin
                r_d.cnt = 16'h0000;
                if (!r_q.hi) begin
                    r_d.hi = 1'b1;
                    r_d.rd_n = 1'b0;
                    r_d.st = adc_seq_pkg::H_RD_LO;
                end else begin
                    r_d = finish(r_d);
                    r_d.done_seen = 1'b1;
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            r_q <= '0;
            r_q.acq_len <= adc_seq_pkg::ACQ_LEN_RST;
            r_q.cs_n <= 1'b1;
            r_q.wr_n <= 1'b1;
            r_q.rd_n <= 1'b1;
            r_q.hready <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    assign HREADYOUT = r_q.hready;
    assign HRDATA = r_q.hrdata;
    assign HRESP = 1'b0;
    assign BUS.cs_n = r_q.cs_n;
    assign BUS.wr_n = r_q.wr_n;
    assign BUS.rd_n = r_q.rd_n;
    assign BUS.hi_byte = r_q.hi;
    assign BUS.d_host = r_q.dout;
    assign BUS.d_host_oe = r_q.d_oe;
    assign BUS.ext_cclk = r_q.ecclk;
endmodule

/* src/adc_seq_pkg.sv */
package adc_seq_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int INT_CCLK_PERIOD_NS = 280;
    localparam int INT_CCLK_HALF = INT_CCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int EXT_CCLK_PERIOD_NS = 400;
    localparam int EXT_CCLK_HALF = EXT_CCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int ACQ_HOLD_EDGE = 4;
    localparam int CONV_CYCLES = 13;
    localparam int RES_W = 10;
    localparam int PCS_HI = 7;
    localparam int PCS_LO = 6;
    localparam int TIMING_BIT = 5;
    localparam int PAIRING_BIT = 4;
    localparam int POLARITY_BIT = 3;
    localparam int CH_HI = 2;
    localparam logic [1:0] PCS_FULL_DOWN = 2'h0;
    localparam logic [1:0] PCS_STANDBY = 2'h1;
    localparam logic [1:0] PCS_INT_CLK = 2'h2;
    localparam logic [1:0] PCS_EXT_CLK = 2'h3;
    localparam logic EXT_MODE_RST = 1'b1;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam int WR_LOW_CYC = 2;
    localparam int RD_LOW_CYC = 3;
    localparam logic [7:0] CMD_OFS = 8'h00;
    localparam logic [7:0] ACQ_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    localparam logic [7:0] RES_OFS = 8'h0C;
    localparam int GO_BIT = 8;
    localparam logic [15:0] ACQ_LEN_RST = 16'h0020;
    typedef enum logic [2:0] {D_IDLE, D_OFF, D_ACQ_INT, D_ACQ_EXT, D_CONV} dev_state_t;
    typedef enum logic [2:0] {H_IDLE, H_WR_LO, H_WR_HI, H_ACQ, H_WAIT, H_RD_LO, H_RD_GAP} host_state_t;
endpackage

/* src/sar_core.sv */
`timescale 1ns/10ps
module sar_core #(
    parameter int W = adc_seq_pkg::RES_W
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic start,
    input wire logic step,
    input wire logic comp_gt,
    output logic [W-1:0] code
);
    typedef struct packed {
        logic [W-1:0] trial;
        logic [W-1:0] bitm;
    } sar_regs_t;
    sar_regs_t r_q;
    sar_regs_t r_d;
    logic [W-1:0] keep;
    always_comb begin
        r_d = r_q;
        keep = comp_gt ? r_q.trial : (r_q.trial & ~r_q.bitm);
        if (start) begin
            r_d.trial = {1'b1, {(W-1){1'b0}}};
            r_d.bitm = {1'b1, {(W-1){1'b0}}};
        end else if (step && (r_q.bitm != '0)) begin
            // one bit decided per step, msb first
            r_d.bitm = r_q.bitm >> 1;
            r_d.trial = keep | (r_q.bitm >> 1);
        end
    end
    always_ff @(posedge clk) begin
        if (!rstn) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end
    assign code = r_q.trial;
endmodule
